// >>> common/seq_map.vh
// constants of the instruction sequencer: bus map, fields, opcodes, timing
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH

// register byte offsets on the bus
`define REG_PC_LOW 4'h0
`define REG_ACC 4'h4
`define REG_STATUS 4'h8
`define REG_CTRL 4'hC

// control register bits
`define CTRL_INT_EN 0
`define CTRL_RESET_VAL 8'h00

// status register bits
`define ST_C 0
`define ST_AC 1
`define ST_Z 2
`define ST_OV 3

// phase numbering inside one instruction cycle
`define PH_T1 2'h0
`define PH_T4 2'h3

// instruction word fields
`define IW_BRANCH 14
`define IW_CALL 13
`define IW_OP_HI 13
`define IW_OP_LO 9
`define IW_DEST 8
`define IW_OPND_HI 7
`define IW_TGT_HI 10

// alu operation codes, opcode values 00..0F
`define ALU_ADD 4'h0
`define ALU_ADC 4'h1
`define ALU_SUB 4'h2
`define ALU_SBC 4'h3
`define ALU_DAA 4'h4
`define ALU_AND 4'h5
`define ALU_OR 4'h6
`define ALU_XOR 4'h7
`define ALU_CPL 4'h8
`define ALU_RR 4'h9
`define ALU_RRC 4'hA
`define ALU_RL 4'hB
`define ALU_RLC 4'hC
`define ALU_INC 4'hD
`define ALU_DEC 4'hE
`define ALU_PASS 4'hF

// sequencing opcodes
`define OP_NOP 5'h10
`define OP_SZ 5'h11
`define OP_SNZ 5'h12
`define OP_SIZ 5'h13
`define OP_SDZ 5'h14
`define OP_RET 5'h15
`define OP_RETURN_FROM_INTERRUPT 5'h16
`define OP_MOVI 5'h17
`define OP_MOVM 5'h18

// reset and stack
`define PC_RESET 11'h000
`define STACK_LEVELS 3'h4

`endif

// >>> hdl/alu8.v
// eight-bit alu with carry, half carry, zero and overflow flags
`timescale 1ns/100ps
`include "seq_map.vh"
module alu8 (
    input wire [3:0] i_op,
    input wire [7:0] i_acc,
    input wire [7:0] i_mem,
    input wire i_carry,
    input wire i_half,
    output reg [7:0] o_result,
    output reg o_carry,
    output reg o_half,
    output reg o_ovf,
    output wire o_zero
);
    reg [8:0] sum;
    reg [4:0] nib;
    reg [7:0] opb;
    reg cin;
    always @* begin
        sum = 9'h000;
        nib = 5'h00;
        opb = i_mem;
        cin = 1'b0;
        o_result = i_mem;
        o_carry = i_carry;
        o_half = i_half;
        o_ovf = 1'b0;
        case (i_op)
            `ALU_ADD, `ALU_ADC, `ALU_SUB, `ALU_SBC: begin
                // subtract as add of complement, carry means no borrow
                if (i_op == `ALU_SUB || i_op == `ALU_SBC) begin
                    opb = ~i_mem;
                end
                if (i_op == `ALU_ADD) begin
                    cin = 1'b0;
                end else if (i_op == `ALU_SUB) begin
                    cin = 1'b1;
                end else begin
                    cin = i_carry;
                end
                sum = {1'b0, i_acc} + {1'b0, opb} + {8'h00, cin};
                nib = {1'b0, i_acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
                o_result = sum[7:0];
                o_carry = sum[8];
                o_half = nib[4];
                o_ovf = (i_acc[7] == opb[7]) && (sum[7] != i_acc[7]);
            end
            `ALU_DAA: begin
                sum = {1'b0, i_acc};
                if (i_half || sum[3:0] > 4'h9) begin
                    sum = sum + 9'h006;
                end
                if (i_carry || sum[8:4] > 5'h09) begin
                    sum = sum + 9'h060;
                end
                o_result = sum[7:0];
                o_carry = i_carry | sum[8];
            end
            `ALU_AND: o_result = i_acc & i_mem;
            `ALU_OR: o_result = i_acc | i_mem;
            `ALU_XOR: o_result = i_acc ^ i_mem;
            `ALU_CPL: o_result = ~i_mem;
            `ALU_RR: o_result = {i_mem[0], i_mem[7:1]};
            `ALU_RRC: begin
                o_result = {i_carry, i_mem[7:1]};
                o_carry = i_mem[0];
            end
            `ALU_RL: o_result = {i_mem[6:0], i_mem[7]};
            `ALU_RLC: begin
                o_result = {i_mem[6:0], i_carry};
                o_carry = i_mem[7];
            end
            `ALU_INC: o_result = i_mem + 8'h01;
            `ALU_DEC: o_result = i_mem - 8'h01;
            default: o_result = i_mem;
        endcase
    end
    assign o_zero = (o_result == 8'h00);
endmodule // alu8

// >>> hdl/seq_core.v
// instruction sequencer: phases, program counter, return stack, execute
`timescale 1ns/100ps
`include "seq_map.vh"
module seq_core #(
    parameter PC_W = 11,
    parameter IW_W = 15,
    parameter DMEM_AW = 4,
    parameter [10:0] INT_VECTOR = 11'h004
) (
    input wire i_clk,
    input wire i_rst,
    output wire [PC_W-1:0] o_imem_addr,
    input wire [IW_W-1:0] i_imem_data,
    input wire i_int_req,
    output reg o_int_ack,
    output wire [3:0] o_instruction_phase_clocks,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    output reg [31:0] o_avs_readdata,
    output wire o_avs_waitrequest
);
    localparam DMEM_DEPTH = 1 << DMEM_AW;

    reg [3:0] phase_reg;
    reg [1:0] phase_num_reg;
    reg [PC_W-1:0] pc_reg;
    reg [PC_W-1:0] pc_next;
    reg [IW_W-1:0] fetch_reg;
    reg [IW_W-1:0] ir_reg;
    reg ir_valid_reg;
    reg [7:0] acc_reg;
    reg [7:0] status_reg;
    reg [7:0] ctrl_reg;
    reg [7:0] dmem [0:DMEM_DEPTH-1];
    reg [PC_W-1:0] stack_mem [0:3];
    reg [1:0] sp_reg;
    reg [2:0] depth_reg;
    reg int_pend_reg;
    reg pcl_pend_reg;
    reg [7:0] pcl_new_reg;
    reg rd_done_reg;
    integer k;

    // decode helpers used by several processes
    function is_branch;
        input [IW_W-1:0] iw;
        begin
            is_branch = iw[`IW_BRANCH];
        end
    endfunction

    function [4:0] opcode;
        input [IW_W-1:0] iw;
        begin
            opcode = iw[`IW_OP_HI:`IW_OP_LO];
        end
    endfunction

    function is_alu;
        input [IW_W-1:0] iw;
        begin
            is_alu = ~iw[`IW_BRANCH] & ~iw[`IW_OP_HI];
        end
    endfunction

    // phase generator
    always @(posedge i_clk) begin
        if (i_rst) begin
            phase_reg <= 4'h1;
            phase_num_reg <= `PH_T1;
        end else begin
            phase_reg <= {phase_reg[2:0], phase_reg[3]};
            phase_num_reg <= phase_num_reg + 2'h1;
        end
    end
    assign o_instruction_phase_clocks = phase_reg;

    wire t1 = (phase_num_reg == `PH_T1);
    wire t4 = (phase_num_reg == `PH_T4);

    assign o_imem_addr = pc_reg;

    // operand fetch and alu
    wire [DMEM_AW-1:0] opnd_addr = ir_reg[DMEM_AW-1:0];
    wire [7:0] mem_val = dmem[opnd_addr];
    wire [4:0] op = opcode(ir_reg);
    reg [3:0] alu_op;
    wire [7:0] alu_res;
    wire alu_c;
    wire alu_ac;
    wire alu_ov;
    wire alu_z;

    always @* begin
        alu_op = `ALU_PASS;
        if (is_alu(ir_reg)) begin
            alu_op = op[3:0];
        end else if (op == `OP_SIZ) begin
            alu_op = `ALU_INC;
        end else if (op == `OP_SDZ) begin
            alu_op = `ALU_DEC;
        end
    end

    alu8 u_alu (
        .i_op(alu_op),
        .i_acc(acc_reg),
        .i_mem(mem_val),
        .i_carry(status_reg[`ST_C]),
        .i_half(status_reg[`ST_AC]),
        .o_result(alu_res),
        .o_carry(alu_c),
        .o_half(alu_ac),
        .o_ovf(alu_ov),
        .o_zero(alu_z)
    );

    // flow decisions for the executing word
    wire stack_full = (depth_reg == `STACK_LEVELS);
    wire exec = ir_valid_reg;
    wire do_jump = exec & is_branch(ir_reg) & ~ir_reg[`IW_CALL];
    wire do_call = exec & is_branch(ir_reg) & ir_reg[`IW_CALL];
    wire do_ret = exec & ~is_branch(ir_reg) &
        (op == `OP_RET || op == `OP_RETURN_FROM_INTERRUPT);
    reg do_skip;

    always @* begin
        do_skip = 1'b0;
        if (exec && !is_branch(ir_reg)) begin
            case (op)
                `OP_SZ: do_skip = (mem_val == 8'h00);
                `OP_SNZ: do_skip = (mem_val != 8'h00);
                `OP_SIZ, `OP_SDZ: do_skip = alu_z;
                default: do_skip = 1'b0;
            endcase
        end
    end

    wire flow = do_jump | do_call | do_ret | do_skip;
    wire take_int = ~flow & int_pend_reg & ~stack_full &
        ctrl_reg[`CTRL_INT_EN];
    wire take_pcl = ~flow & ~take_int & pcl_pend_reg;
    wire do_push = do_call | take_int;
    wire [PC_W-1:0] pop_val = stack_mem[sp_reg - 2'h1];

    always @* begin
        pc_next = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
        if (do_jump || do_call) begin
            pc_next = ir_reg[`IW_TGT_HI:0];
        end else if (do_ret) begin
            pc_next = pop_val;
        end else if (do_skip) begin
            pc_next = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
        end else if (take_int) begin
            pc_next = INT_VECTOR;
        end else if (take_pcl) begin
            pc_next = {pc_reg[PC_W-1:8], pcl_new_reg};
        end
    end

    // fetch, execute and commit
    always @(posedge i_clk) begin
        if (i_rst) begin
            pc_reg <= `PC_RESET;
            fetch_reg <= {IW_W{1'b0}};
            ir_reg <= {IW_W{1'b0}};
            ir_valid_reg <= 1'b0;
            acc_reg <= 8'h00;
            status_reg <= 8'h00;
            o_int_ack <= 1'b0;
            for (k = 0; k < DMEM_DEPTH; k = k + 1) begin
                dmem[k] <= 8'h00;
            end
        end else begin
            o_int_ack <= 1'b0;
            if (t1) begin
                fetch_reg <= i_imem_data;
            end
            if (t4) begin
                pc_reg <= pc_next;
                ir_reg <= fetch_reg;
                // a flow change turns the fetched word into a dummy
                ir_valid_reg <= ~(flow | take_int | take_pcl);
                o_int_ack <= take_int;
                if (exec && is_alu(ir_reg)) begin
                    status_reg[`ST_C] <= alu_c;
                    status_reg[`ST_AC] <= alu_ac;
                    status_reg[`ST_OV] <= alu_ov;
                    status_reg[`ST_Z] <= alu_z;
                    if (ir_reg[`IW_DEST]) begin
                        dmem[opnd_addr] <= alu_res;
                    end else begin
                        acc_reg <= alu_res;
                    end
                end
                if (exec && (op == `OP_SIZ || op == `OP_SDZ) &&
                        !is_branch(ir_reg)) begin
                    status_reg[`ST_Z] <= alu_z;
                    if (ir_reg[`IW_DEST]) begin
                        dmem[opnd_addr] <= alu_res;
                    end else begin
                        acc_reg <= alu_res;
                    end
                end
                if (exec && !is_branch(ir_reg) && op == `OP_MOVI) begin
                    acc_reg <= ir_reg[`IW_OPND_HI:0];
                end
                if (exec && !is_branch(ir_reg) && op == `OP_MOVM) begin
                    dmem[opnd_addr] <= acc_reg;
                end
            end
        end
    end

    // return stack, pointer wraps so the oldest entry is overwritten
    always @(posedge i_clk) begin
        if (i_rst) begin
            sp_reg <= 2'h0;
            depth_reg <= 3'h0;
            for (k = 0; k < 4; k = k + 1) begin
                stack_mem[k] <= `PC_RESET;
            end
        end else if (t4) begin
            if (do_push) begin
                stack_mem[sp_reg] <= pc_reg;
                sp_reg <= sp_reg + 2'h1;
                if (!stack_full) begin
                    depth_reg <= depth_reg + 3'h1;
                end
            end else if (do_ret) begin
                sp_reg <= sp_reg - 2'h1;
                if (depth_reg != 3'h0) begin
                    depth_reg <= depth_reg - 3'h1;
                end
            end
        end
    end

    // interrupt request flag, a new request wins over the acknowledge
    always @(posedge i_clk) begin
        if (i_rst) begin
            int_pend_reg <= 1'b0;
        end else if (i_int_req) begin
            int_pend_reg <= 1'b1;
        end else if (t4 && take_int) begin
            int_pend_reg <= 1'b0;
        end
    end

    // bus slave
    wire wr_pcl = i_avs_write && i_avs_address == `REG_PC_LOW &&
        i_avs_byteenable[0];
    assign o_avs_waitrequest = (i_avs_read & ~rd_done_reg) |
        (wr_pcl & pcl_pend_reg);

    always @(posedge i_clk) begin
        if (i_rst) begin
            pcl_pend_reg <= 1'b0;
            pcl_new_reg <= 8'h00;
            ctrl_reg <= `CTRL_RESET_VAL;
            rd_done_reg <= 1'b0;
            o_avs_readdata <= 32'h00000000;
        end else begin
            if (t4 && take_pcl) begin
                pcl_pend_reg <= 1'b0;
            end
            if (wr_pcl && !pcl_pend_reg) begin
                pcl_pend_reg <= 1'b1;
                pcl_new_reg <= i_avs_writedata[7:0];
            end
            if (i_avs_write && i_avs_address == `REG_CTRL &&
                    i_avs_byteenable[0]) begin
                ctrl_reg <= i_avs_writedata[7:0];
            end
            rd_done_reg <= i_avs_read & ~rd_done_reg;
            if (i_avs_read && !rd_done_reg) begin
                case (i_avs_address)
                    `REG_PC_LOW:
                        o_avs_readdata <= {24'h000000, pc_reg[7:0]};
                    `REG_ACC: o_avs_readdata <= {24'h000000, acc_reg};
                    `REG_STATUS: o_avs_readdata <= {24'h000000, status_reg};
                    `REG_CTRL: o_avs_readdata <= {24'h000000, ctrl_reg};
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // seq_core

// >>> tb/prog_rom.sv
// behavioural program memory holding the test program
`timescale 1ns/100ps
module prog_rom (
    input wire [10:0] i_addr,
    output wire [14:0] o_data
);
    reg [14:0] mem [0:2047];
    integer k;
    assign o_data = mem[i_addr];
    initial begin
        for (k = 0; k < 2048; k = k + 1) begin
            mem[k] = 15'h2000;
        end
        // start, handler, main line and idle loop
        mem[11'h000] = 15'h4008;
        mem[11'h004] = 15'h2C00;
        mem[11'h008] = 15'h2E7F;
        mem[11'h009] = 15'h3100;
        mem[11'h00A] = 15'h0000;
        mem[11'h00B] = 15'h6010;
        mem[11'h00D] = 15'h400C;
        // subroutine: taken skip, add, return
        mem[11'h010] = 15'h2201;
        mem[11'h011] = 15'h2EEE;
        mem[11'h012] = 15'h0000;
        mem[11'h013] = 15'h2A00;
        // page jump target, five nested calls
        mem[11'h020] = 15'h6040;
        mem[11'h021] = 15'h2EBD;
        mem[11'h022] = 15'h4022;
        mem[11'h040] = 15'h6050;
        mem[11'h042] = 15'h4041;
        mem[11'h050] = 15'h6060;
        mem[11'h051] = 15'h2A00;
        mem[11'h060] = 15'h6070;
        mem[11'h061] = 15'h2A00;
        mem[11'h070] = 15'h6078;
        mem[11'h071] = 15'h2E5A;
        mem[11'h072] = 15'h2A00;
        mem[11'h078] = 15'h2A00;
    end
endmodule // prog_rom

// >>> tb/seq_core_chk.sv
// concurrent checks on the sequencer ports
`timescale 1ns/100ps
`include "seq_map.vh"
module seq_core_chk #(
    parameter PC_W = 11,
    parameter IW_W = 15,
    parameter [10:0] INT_VECTOR = 11'h004
) (
    input wire i_clk,
    input wire i_rst,
    input wire [PC_W-1:0] o_imem_addr,
    input wire [IW_W-1:0] i_imem_data,
    input wire i_int_req,
    input wire o_int_ack,
    input wire [3:0] o_instruction_phase_clocks,
    input wire [3:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    input wire [31:0] o_avs_readdata,
    input wire o_avs_waitrequest
);
    wire [3:0] ph = o_instruction_phase_clocks;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence ph_walk;
        ph == 4'h2 ##1 ph == 4'h4 ##1 ph == 4'h8 ##1 ph == 4'h1;
    endsequence
    sequence rd_first;
        i_avs_read && !($past(i_avs_read) && $past(o_avs_waitrequest));
    endsequence
    property reset_load_p;
        disable iff (1'b0) i_rst |=> ph == 4'h1 && o_imem_addr == 11'h000
            && !o_int_ack && o_avs_readdata == 32'h0;
    endproperty
    phase_onehot_a: assert property ($onehot(ph))
        else $error("phase clocks not one-hot");
    phase_walk_a: assert property (ph == 4'h1 |=> ph_walk)
        else $error("phase order broken");
    fetch_hold_a: assert property (!ph[0] |-> $stable(o_imem_addr))
        else $error("fetch address moved outside phase one");
    reset_load_a: assert property (reset_load_p)
        else $error("reset state wrong");
    ack_vector_a: assert property (o_int_ack |-> ph == 4'h1 &&
        o_imem_addr == INT_VECTOR ##1 !o_int_ack)
        else $error("interrupt entry wrong");
    read_wait_a: assert property (rd_first |-> o_avs_waitrequest)
        else $error("read answered without wait");
    read_done_a: assert property (i_avs_read && $past(i_avs_read)
        && $past(o_avs_waitrequest) |-> !o_avs_waitrequest)
        else $error("read wait too long");
    write_fast_a: assert property (i_avs_write &&
        i_avs_address != `REG_PC_LOW |-> !o_avs_waitrequest)
        else $error("write stalled");
    unmapped_zero_a: assert property (i_avs_read &&
        !o_avs_waitrequest && i_avs_address[1:0] != 2'h0
        |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
endmodule // seq_core_chk
bind seq_core seq_core_chk #(.PC_W(PC_W), .IW_W(IW_W),
    .INT_VECTOR(INT_VECTOR)) chk_i (.i_clk(i_clk), .i_rst(i_rst),
    .o_imem_addr(o_imem_addr), .i_imem_data(i_imem_data),
    .i_int_req(i_int_req), .o_int_ack(o_int_ack),
    .o_instruction_phase_clocks(o_instruction_phase_clocks),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest));

// >>> tb/mcu_fetch_pc_stack_sequencer_tb_top.sv
// self-checking bench for the instruction sequencer
`timescale 1ns/100ps
`include "seq_map.vh"
module mcu_fetch_pc_stack_sequencer_tb_top;
    reg i_clk = 1'b0;
    reg i_rst = 1'b1;
    reg i_int_req = 1'b0;
    reg [3:0] i_avs_address = 4'h0;
    reg i_avs_read = 1'b0;
    reg i_avs_write = 1'b0;
    reg [31:0] i_avs_writedata = 32'h0;
    reg [3:0] i_avs_byteenable = 4'hF;
    wire [10:0] o_imem_addr;
    wire [14:0] i_imem_data;
    wire o_int_ack;
    wire [3:0] o_instruction_phase_clocks;
    wire [31:0] o_avs_readdata;
    wire o_avs_waitrequest;
    int fails = 0;
    int comparisons = 0;
    int n;
    reg [7:0] rd;

    initial begin
        forever #12.5 i_clk = ~i_clk;
    end

    seq_core uut (.i_clk(i_clk), .i_rst(i_rst), .o_imem_addr(o_imem_addr),
        .i_imem_data(i_imem_data), .i_int_req(i_int_req),
        .o_int_ack(o_int_ack),
        .o_instruction_phase_clocks(o_instruction_phase_clocks),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest));
    prog_rom rom (.i_addr(o_imem_addr), .o_data(i_imem_data));

    task give_verdict;
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // one bus transfer, held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [7:0] wd,
        output logic [7:0] d);
        int k;
        k = 0;
        // start right after a rising edge, sample settled values mid-cycle
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_writedata <= {24'h0, wd};
        @(negedge i_clk);
        while (o_avs_waitrequest !== 1'b0 && k < 20) begin
            k = k + 1;
            @(negedge i_clk);
        end
        d = o_avs_readdata[7:0];
        chk(32'(o_avs_waitrequest), 32'h0);
        // the request is taken at this rising edge, then released
        @(posedge i_clk);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_clk);
    endtask

    task rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, a, 8'h00, d);
        chk(32'(d), 32'(exp));
    endtask

    task step;
        @(negedge i_clk);
        n = n + 1;
    endtask

    task wait_addr(input logic [10:0] a);
        n = 0;
        while (o_imem_addr !== a && n < 2000) step;
        chk(32'(o_imem_addr), 32'(a));
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        fails = fails + 1;
        give_verdict;
    end

    initial begin
        repeat (7) @(posedge i_clk);
        chk(32'(o_instruction_phase_clocks), 32'h1);
        chk(32'(o_imem_addr), 32'h0);
        @(posedge i_clk);
        i_rst <= 1'b0;
        rdchk(`REG_ACC, 8'h00);
        rdchk(`REG_STATUS, 8'h00);
        rdchk(`REG_CTRL, `CTRL_RESET_VAL);
        wait_addr(11'h012);
        // idle loop: one plain cycle plus a two-cycle jump
        wait_addr(11'h00C);
        n = 0;
        while (o_imem_addr === 11'h00C && n < 50) step;
        while (o_imem_addr !== 11'h00C && n < 50) step;
        chk(32'(n), 32'd12);
        bus(1'b1, `REG_ACC, 8'h11, rd);
        rdchk(`REG_ACC, 8'h7D);
        rdchk(`REG_STATUS, 8'h03);
        bus(1'b1, 4'h2, 8'hA5, rd);
        rdchk(4'h2, 8'h00);
        bus(1'b1, `REG_CTRL, 8'h01, rd);
        rdchk(`REG_CTRL, 8'h01);
        i_int_req <= 1'b1;
        @(posedge i_clk);
        i_int_req <= 1'b0;
        n = 0;
        while (o_int_ack !== 1'b1 && n < 100) step;
        chk(32'(o_imem_addr), 32'h004);
        wait_addr(11'h00D);
        bus(1'b1, `REG_CTRL, 8'h00, rd);
        bus(1'b1, `REG_PC_LOW, 8'h20, rd);
        wait_addr(11'h042);
        rdchk(`REG_ACC, 8'h5A);
        // reset again in mid-run, then rerun the call path
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk(32'(o_imem_addr), 32'h0);
        i_rst <= 1'b0;
        rdchk(`REG_CTRL, 8'h00);
        wait_addr(11'h012);
        wait_addr(11'h00D);
        give_verdict;
    end
endmodule // mcu_fetch_pc_stack_sequencer_tb_top
